/* bench/pwt_pulse_src.sv */
// Behavioural pulse source on the measure input pin
`timescale 1ns/1ps
module pwt_pulse_src(
	input wire clk,
	input wire go,
	input wire [7:0] hi,
	input wire [7:0] lo,
	input wire [3:0] num,
	output reg pin
);
	initial pin = 1'h0;
	// Widths kept well above two cycles so no edge is lost
	always @(posedge go)
	begin
		repeat (num)
		begin
			@(posedge clk);
			pin <= 1'h1;
			repeat (hi) @(posedge clk);
			pin <= 1'h0;
			repeat (lo - 1) @(posedge clk);
		end
	end
endmodule

/* bench/pwt_timer_asserts.sv */
// Port checker for the pulse width timer
`timescale 1ns/1ps
module pwt_timer_chk(
	input wire clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire toggle_output_pin,
	input wire ovf_req,
	input wire end_req
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	wire csr_rd = pready && !pwrite && paddr == 32'h0;
	property p_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_wait: assert property (p_wait) else $error("late answer");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("long answer");
	property p_err;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_rst;
		$rose(rstn) |-> !ovf_req && !end_req && !toggle_output_pin;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_rmw;
		csr_rd && pwdata[31] |-> prdata[15:14] == 2'h3;
	endproperty
	a_rmw: assert property (p_rmw) else $error("marker read");
	property p_eq;
		csr_rd |-> prdata[15] == prdata[14];
	endproperty
	a_eq: assert property (p_eq) else $error("run bits differ");
	property p_ovf;
		$fell(ovf_req) |-> $past(pwrite && pready) ||
			$past(pwrite && pready, 2);
	endproperty
	a_ovf: assert property (p_ovf) else $error("ovf dropped");
	property p_end;
		$fell(end_req) |-> $past(pwrite && pready) ||
			$past(pwrite && pready, 2);
	endproperty
	a_end: assert property (p_end) else $error("end dropped");
	c_ovf: cover property ($rose(ovf_req));
	c_end: cover property ($rose(end_req));
	c_tog: cover property ($changed(toggle_output_pin));
endmodule
bind pwt_timer pwt_timer_chk u_chk(
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.toggle_output_pin(toggle_output_pin), .ovf_req(ovf_req),
	.end_req(end_req)
);

/* bench/test_pwt_timer.sv */
// Self-checking bench for the pulse width timer
`timescale 1ns/1ps
module test_pwt_timer;
	typedef struct {logic [31:0] a; logic [31:0] d; logic e;} pwt_row_t;
	pwt_row_t rows[5] = '{'{32'h0, 32'h0, 1'h0}, '{32'h4, 32'h0, 1'h0},
		'{32'h8, 32'h0, 1'h0}, '{32'hC, 32'h0, 1'h0},
		'{32'h10, 32'h0, 1'h1}};
	typedef struct {logic [31:0] c; logic [31:0] f; logic n; int l; int h;}
		pwt_wrow_t;
	// Filtered row first so the later rows run with the filter off
	pwt_wrow_t wrows[5] = '{'{32'h405, 32'h1, 1'h0, 0, 0},
		'{32'h402, 32'h0, 1'h1, 9, 11}, '{32'h403, 32'h0, 1'h1, 79, 81},
		'{32'h406, 32'h0, 1'h1, 9, 11}, '{32'h407, 32'h0, 1'h1, 19, 21}};
	reg clk = 1'h0;
	reg rstn = 1'h0;
	reg psel = 1'h0;
	reg penable = 1'h0;
	reg pwrite = 1'h0;
	reg [31:0] paddr = 32'h0;
	reg [31:0] pwdata = 32'h0;
	reg go = 1'h0;
	reg [7:0] hi = 8'h28;
	reg [7:0] lo = 8'h28;
	reg [3:0] num = 4'h1;
	wire [31:0] prdata;
	wire pready, pslverr, pin, tog, ovf, endr;
	int miscompares = 0;
	int checks = 0;
	int c;
	logic [31:0] r;
	logic e;
	always #2 clk = ~clk;
	pwt_timer #(.FILT_US0(1), .FILT_US1(1), .FILT_US2(1), .FILT_US3(1))
		dut(.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pulse_measure_input_pin(pin), .toggle_output_pin(tog),
		.ovf_req(ovf), .end_req(endr));
	pwt_pulse_src src(.clk(clk), .go(go), .hi(hi), .lo(lo), .num(num),
		.pin(pin));
	task chk(input string s, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x)
		begin
			miscompares++;
			$display("wrong value %s exp %h got %h", s, x, g);
		end
	endtask
	task rng(input string s, input int l, input int h, input logic [31:0] g);
		checks++;
		if (((g >= l) && (g <= h)) !== 1'h1)
		begin
			miscompares++;
			$display("wrong value %s exp %0d to %0d got %h", s, l, h, g);
		end
	endtask
	task bus(input [31:0] a, input [31:0] w, input logic wr);
		psel <= 1'h1;
		paddr <= a;
		pwdata <= w;
		pwrite <= wr;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	// Sampled on the falling edge so the pin value has settled
	task tg;
		logic p;
		p = tog;
		for (c = 0; tog === p && c < 9000; c++) @(negedge clk);
	endtask
	task end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		miscompares++;
		end_of_test;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		foreach (rows[i])
		begin
			bus(rows[i].a, 32'h0, 1'h0);
			chk("slverr", rows[i].e, e);
			if (!rows[i].e) chk("reset value", rows[i].d, r);
		end
		bus(32'h4, 32'hFFFC, 1'h1);
		bus(32'h0, 32'h4800, 1'h1);
		for (c = 0; ovf !== 1'h1 && c < 3000; c++) @(posedge clk);
		rng("wrap delay", 8, 24, c);
		bus(32'h0, 32'h80000000, 1'h0);
		chk("csr after wrap", 32'hE900, r);
		chk("pin single", 32'h0, tog);
		bus(32'h4, 32'h0, 1'h0);
		chk("counter", 32'h0, r);
		bus(32'h0, 32'h49, 1'h1);
		bus(32'h4, 32'hFFFE, 1'h1);
		bus(32'h0, 32'h4049, 1'h1);
		@(negedge clk);
		tg;
		tg;
		chk("reload period", 32'h20, c);
		@(posedge clk);
		bus(32'h4, 32'hFFF0, 1'h1);
		bus(32'h4, 32'h0, 1'h0);
		chk("reload value", 32'hFFF0, r);
		bus(32'h0, 32'hC049, 1'h1);
		bus(32'h0, 32'h0, 1'h0);
		chk("run bits", 32'h3, r[15:14]);
		@(negedge clk);
		tg;
		tg;
		chk("new period", 32'h100, c);
		@(posedge clk);
		bus(32'h0, 32'h8049, 1'h1);
		bus(32'h0, 32'h0, 1'h0);
		chk("halted", 32'h0, r[15:14]);
		bus(32'h0, 32'h405, 1'h1);
		bus(32'h0, 32'h4405, 1'h1);
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		for (c = 0; endr !== 1'h1 && c < 3000; c++) @(posedge clk);
		chk("end request", 32'h1, endr);
		bus(32'h4, 32'h0, 1'h0);
		rng("high width", 9, 11, r);
		bus(32'h0, 32'h0, 1'h0);
		chk("csr width end", 32'h1405, r);
		num <= 4'h5;
		foreach (wrows[i])
		begin
			bus(32'h0, 32'h8000, 1'h1);
			bus(32'hC, wrows[i].f, 1'h1);
			bus(32'h0, wrows[i].c, 1'h1);
			bus(32'h0, wrows[i].c | 32'h4000, 1'h1);
			go <= 1'h1;
			@(posedge clk);
			go <= 1'h0;
			repeat (450) @(posedge clk);
			chk("width end", wrows[i].n, endr);
			bus(32'h4, 32'h0, 1'h0);
			if (wrows[i].n)
				rng("width", wrows[i].l, wrows[i].h, r);
		end
		bus(32'h0, 32'hC, 1'h1);
		bus(32'h0, 32'h400C, 1'h1);
		hi <= 8'h20;
		lo <= 8'h20;
		num <= 4'h3;
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		repeat (240) @(posedge clk);
		bus(32'h0, 32'h0, 1'h0);
		chk("csr overrun", 32'h69, r[15:9]);
		bus(32'h4, 32'h0, 1'h0);
		rng("period result", 15, 17, r);
		bus(32'h0, 32'h0, 1'h0);
		chk("error cleared", 32'h0, r[9]);
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		bus(32'h4, 32'h0, 1'h0);
		chk("counter after reset", 32'h0, r);
		bus(32'h0, 32'h0, 1'h0);
		chk("csr after reset", 32'h0, r);
		chk("pin after reset", 32'h0, tog);
		bus(32'h0, 32'h800C, 1'h1);
		end_of_test;
	end
endmodule

/* verilog/pwt_defines.vh */
// Register map, field positions and constants of the pulse width timer
`ifndef PWT_DEFINES_VH
`define PWT_DEFINES_VH
`define PWT_ADDR_W 4
`define PWT_OFS_CSR 4'h0
`define PWT_OFS_DATA 4'h4
`define PWT_OFS_DIV 4'h8
`define PWT_OFS_FILT 4'hC
`define PWT_B_RUN 15
`define PWT_B_STOP 14
`define PWT_B_OVF 13
`define PWT_B_END 12
`define PWT_B_OVIE 11
`define PWT_B_EDIE 10
`define PWT_B_ERR 9
`define PWT_B_TOG 8
`define PWT_B_CKS 6
`define PWT_B_SC 3
`define PWT_B_MOD 0
`define PWT_B_RMW 31
`define PWT_B_FEN 0
`define PWT_B_FSW 1
`define PWT_MOD_TMR 3'h0
`define PWT_MOD_TMRP 3'h1
`define PWT_MOD_ALL 3'h2
`define PWT_MOD_DIVP 3'h3
`define PWT_MOD_RR 3'h4
`define PWT_MOD_HI 3'h5
`define PWT_MOD_LO 3'h6
`define PWT_MOD_FF 3'h7
`define PWT_CNT_MAX 16'hFFFF
`define PWT_CNT_ZERO 16'h0000
`define PWT_DIV4 5'h03
`define PWT_DIV16 5'h0F
`define PWT_DIV32 5'h1F
`define PWT_FILT_US0 2
`define PWT_FILT_US1 32
`define PWT_FILT_US2 64
`define PWT_FILT_US3 128
`define PWT_CLK_MHZ 250
`endif

/* verilog/pwt_timer.v */
// Pulse width count timer with APB register access
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "pwt_defines.vh"
// Functional notes
// - Single-shot timer counts, stops on wrap
// - Reload timer wrap reloads, toggles, continues
// - Reload start copies reload value first
// - New reload value used at next reload
// - Reload timer runs until stop or reset
// - Single-shot data register is the counter
// - Single-shot toggles bit but pin not driven
// - Timer wrap raises overflow request
// - Width mode requests on end and overflow
// - Wait start edge, clear, then count
// - End edge stops; single-shot then halts
// - Continuous end copies to buffer; pulse modes wait, period modes restart
// - Clock select divides by 4, 16, 32
// - Single/continuous bit selects count style
// - Three-bit mode field decodes eight modes
// - Reset selects single-shot timer
// - Start 0/stop 1 starts; 1/0 halts
// - Run bits read equal; RMW reads one
// - Timer mode counts right after start
// - Restart: none single-shot, reload in reload
// - Restart with overflow keeps flag, toggle
// - Width restart aborts count, waits start
// - Restart with end edge keeps flag, buffer
// - Filter enable bit bypasses or applies filter
// - Filter width codes 2, 32, 64, 128 us
// - Divided period input divide 4 to 256
// - Overwritten unread result sets error flag
module pwt_timer #(
	parameter FILT_US0 = `PWT_FILT_US0,
	parameter FILT_US1 = `PWT_FILT_US1,
	parameter FILT_US2 = `PWT_FILT_US2,
	parameter FILT_US3 = `PWT_FILT_US3
)(
	input wire clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire pulse_measure_input_pin,
	output reg toggle_output_pin,
	output reg ovf_req,
	output reg end_req
);
	// Filter windows in cycles, min time rounds up
	localparam integer FC0 = (FILT_US0 * `PWT_CLK_MHZ);
	localparam integer FC1 = (FILT_US1 * `PWT_CLK_MHZ);
	localparam integer FC2 = (FILT_US2 * `PWT_CLK_MHZ);
	localparam integer FC3 = (FILT_US3 * `PWT_CLK_MHZ);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_CNT = 3'b100;

	reg [2:0] st_r;
	reg [15:0] cnt_r;
	reg [15:0] data_r;
	reg [2:0] mode_r;
	reg sc_r;
	reg [1:0] cks_r;
	reg tog_r;
	reg ovf_r;
	reg end_r;
	reg ovie_r;
	reg edie_r;
	reg err_r;
	reg unread_r;
	reg [1:0] input_divide_ratio_r;
	reg fen_r;
	reg [1:0] fsw_r;
	reg [4:0] pre_r;
	reg [2:0] sync_r;
	reg filt_r;
	reg [15:0] fcnt_r;
	reg prev_r;
	reg [7:0] ediv_r;

	function is_width;
		input [2:0] m;
		begin
			is_width = (m != `PWT_MOD_TMR) && (m != `PWT_MOD_TMRP);
		end
	endfunction

	wire tmr_mode = !is_width(mode_r);
	wire running = (st_r != ST_IDLE);
	wire wr = psel && penable && pwrite && pready;
	wire rd = psel && penable && !pwrite && pready;
	wire [3:0] adr = paddr[`PWT_ADDR_W-1:0];
	wire wr_csr = wr && (adr == `PWT_OFS_CSR);
	wire wr_data = wr && (adr == `PWT_OFS_DATA);
	wire rd_data = rd && (adr == `PWT_OFS_DATA);
	wire start_cmd = wr_csr && !pwdata[`PWT_B_RUN]
		&& pwdata[`PWT_B_STOP];
	wire stop_cmd = wr_csr && pwdata[`PWT_B_RUN]
		&& !pwdata[`PWT_B_STOP];

	// Count clock enable from prescaler
	reg [4:0] pre_lim;
	always @*
	begin
		case (cks_r)
			2'b01: pre_lim = `PWT_DIV16;
			2'b10: pre_lim = `PWT_DIV32;
			default: pre_lim = `PWT_DIV4;
		endcase
	end
	wire cen = (pre_r >= pre_lim);

	// Filter window select
	reg [15:0] flim;
	always @*
	begin
		case (fsw_r)
			2'b01: flim = FC1[15:0];
			2'b10: flim = FC2[15:0];
			2'b11: flim = FC3[15:0];
			default: flim = FC0[15:0];
		endcase
	end
	wire in_sync = sync_r[2];
	wire agree = (sync_r[1] == sync_r[2]);
	wire sig = fen_r ? filt_r : in_sync;
	wire rise = sig && !prev_r;
	wire fall = !sig && prev_r;
	reg [7:0] dmask;
	always @*
	begin
		case (input_divide_ratio_r)
			2'b01: dmask = 8'h0F;
			2'b10: dmask = 8'h3F;
			2'b11: dmask = 8'hFF;
			default: dmask = 8'h03;
		endcase
	end
	// Divided input completes one period on wrap
	wire dwrap = fall && ((ediv_r & dmask) == (dmask & 8'hFF));

	reg start_edge;
	reg end_edge;
	always @*
	begin
		case (mode_r)
			`PWT_MOD_ALL:
			begin
				start_edge = rise || fall;
				end_edge = rise || fall;
			end
			`PWT_MOD_DIVP:
			begin
				start_edge = fall;
				end_edge = dwrap;
			end
			`PWT_MOD_RR:
			begin
				start_edge = rise;
				end_edge = rise;
			end
			`PWT_MOD_HI:
			begin
				start_edge = rise;
				end_edge = fall;
			end
			`PWT_MOD_LO:
			begin
				start_edge = fall;
				end_edge = rise;
			end
			`PWT_MOD_FF:
			begin
				start_edge = fall;
				end_edge = fall;
			end
			default:
			begin
				start_edge = 1'b0;
				end_edge = 1'b0;
			end
		endcase
	end
	wire period_mode = (mode_r == `PWT_MOD_ALL) || (mode_r == `PWT_MOD_DIVP)
		|| (mode_r == `PWT_MOD_RR) || (mode_r == `PWT_MOD_FF);
	wire wrap = cen && (cnt_r == `PWT_CNT_MAX);
	wire tmr_ovf = running && tmr_mode && wrap;
	wire pw_ovf = (st_r == ST_CNT) && !tmr_mode && wrap;
	wire pw_end = (st_r == ST_CNT) && !tmr_mode && end_edge;

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_r <= 3'b000;
			filt_r <= 1'b0;
			fcnt_r <= 16'h0000;
			prev_r <= 1'b0;
			ediv_r <= 8'h00;
		end
		else
		begin
			sync_r <= {sync_r[1:0], pulse_measure_input_pin};
			if (!agree || in_sync == filt_r)
				fcnt_r <= 16'h0000;
			else if (fcnt_r >= flim)
			begin
				filt_r <= in_sync;
				fcnt_r <= 16'h0000;
			end
			else
				fcnt_r <= fcnt_r + 16'h0001;
			prev_r <= sig;
			if (!running || st_r == ST_WAIT)
				ediv_r <= 8'h00;
			else if (fall)
				ediv_r <= ediv_r + 8'h01;
		end
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= ST_IDLE;
			cnt_r <= `PWT_CNT_ZERO;
			data_r <= `PWT_CNT_ZERO;
			mode_r <= `PWT_MOD_TMR;
			sc_r <= 1'b0;
			cks_r <= 2'b00;
			tog_r <= 1'b0;
			ovf_r <= 1'b0;
			end_r <= 1'b0;
			ovie_r <= 1'b0;
			edie_r <= 1'b0;
			err_r <= 1'b0;
			unread_r <= 1'b0;
			input_divide_ratio_r <= 2'b00;
			fen_r <= 1'b0;
			fsw_r <= 2'b00;
			pre_r <= 5'h00;
			toggle_output_pin <= 1'b0;
			ovf_req <= 1'b0;
			end_req <= 1'b0;
		end
		else
		begin
			// Prescaler kept free in continuous period modes
			if (!running || cen)
				pre_r <= 5'h00;
			else
				pre_r <= pre_r + 5'h01;
			if (pw_end && !(sc_r && period_mode))
				pre_r <= 5'h00;
			// Register writes; CSR setup and divide ratio only while stopped, filter any time
			if (wr_csr && !running)
			begin
				mode_r <= pwdata[`PWT_B_MOD+2:`PWT_B_MOD];
				sc_r <= pwdata[`PWT_B_SC];
				cks_r <= pwdata[`PWT_B_CKS+1:`PWT_B_CKS];
				tog_r <= pwdata[`PWT_B_TOG];
			end
			if (wr_csr)
			begin
				ovie_r <= pwdata[`PWT_B_OVIE];
				edie_r <= pwdata[`PWT_B_EDIE];
				if (!pwdata[`PWT_B_OVF])
					ovf_r <= 1'b0;
				if (!pwdata[`PWT_B_END])
					end_r <= 1'b0;
			end
			if (wr && adr == `PWT_OFS_DIV && !running)
				input_divide_ratio_r <= pwdata[1:0];
			if (wr && adr == `PWT_OFS_FILT)
			begin
				fen_r <= pwdata[`PWT_B_FEN];
				fsw_r <= pwdata[`PWT_B_FSW+1:`PWT_B_FSW];
			end
			if (rd_data)
			begin
				err_r <= 1'b0;
				unread_r <= 1'b0;
			end
			// Single-shot timer: data port is the counter
			if (wr_data && tmr_mode && !sc_r && !running)
				cnt_r <= pwdata[15:0];
			if (wr_data && tmr_mode && sc_r)
				data_r <= pwdata[15:0];
			case (st_r)
				ST_IDLE:
				begin
					if (start_cmd && tmr_mode)
					begin
						st_r <= ST_CNT;
						if (sc_r)
							cnt_r <= data_r;
					end
					else if (start_cmd)
						st_r <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (stop_cmd)
						st_r <= ST_IDLE;
					else if (start_edge)
					begin
						cnt_r <= `PWT_CNT_ZERO;
						st_r <= ST_CNT;
					end
				end
				ST_CNT:
				begin
					if (tmr_mode)
					begin
						if (cen)
							cnt_r <= cnt_r + 16'h0001;
						if (tmr_ovf)
							tog_r <= !tog_r;
						if (sc_r && (tmr_ovf || start_cmd))
							cnt_r <= data_r;
						if (stop_cmd || (tmr_ovf && !sc_r))
							st_r <= ST_IDLE;
					end
					else
					begin
						if (cen && !pw_end)
							cnt_r <= cnt_r + 16'h0001;
						if (pw_end && sc_r)
						begin
							data_r <= cnt_r;
							unread_r <= 1'b1;
							if (unread_r && !rd_data)
								err_r <= 1'b1;
						end
						if (stop_cmd)
							st_r <= ST_IDLE;
						else if (start_cmd)
							st_r <= ST_WAIT;
						else if (pw_end && !sc_r)
							st_r <= ST_IDLE;
						else if (pw_end && period_mode)
							cnt_r <= `PWT_CNT_ZERO;
						else if (pw_end)
							st_r <= ST_WAIT;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
			// Flags: hardware set wins over software clear
			if (tmr_ovf || pw_ovf)
				ovf_r <= 1'b1;
			if (pw_end)
				end_r <= 1'b1;
			ovf_req <= ovie_r && (ovf_r || tmr_ovf || pw_ovf);
			end_req <= edie_r && (end_r || pw_end);
			toggle_output_pin <= tog_r && sc_r
				&& (mode_r == `PWT_MOD_TMRP);
		end
	end

	// APB answers in one wait state
	wire [15:0] csr_rd = {pwdata[`PWT_B_RMW] ? 2'b11 : {running, running},
		ovf_r, end_r, ovie_r, edie_r, err_r, tog_r, cks_r, 2'b00, sc_r,
		mode_r};
	wire [15:0] data_rd = (!sc_r || tmr_mode) ? (sc_r ? data_r : cnt_r)
		: data_r;
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && penable && !pready)
			begin
				case (adr)
					`PWT_OFS_CSR: prdata <= {16'h0000, csr_rd[15:0]};
					`PWT_OFS_DATA: prdata <= {16'h0000, data_rd};
					`PWT_OFS_DIV: prdata <= {30'h00000000, input_divide_ratio_r};
					`PWT_OFS_FILT: prdata <= {29'h00000000, fsw_r, fen_r};
					default: pslverr <= 1'b1;
				endcase
				if (paddr[31:`PWT_ADDR_W] != 28'h0000000)
					pslverr <= 1'b1;
			end
		end
	end
endmodule
